// ### logic/fswp_pkg.sv
// constants shared by the status and write-protection block
package fswp_pkg;
  // status register field positions and reset value
  localparam int unsigned BUSY_BIT    = 0;
  localparam int unsigned LATCH_BIT   = 1;
  localparam int unsigned PROTECT_LSB = 2;
  localparam int unsigned PROTECT_MSB = 5;
  localparam int unsigned QUAD_BIT    = 6;
  localparam int unsigned LOCK_BIT    = 7;
  localparam logic [7:0]  STATUS_RESET = 8'h00;

  // opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK   = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK     = 8'h04;
  localparam logic [7:0] OP_STATUS_READ    = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
  localparam logic [7:0] OP_FUNCTION_WRITE = 8'h42;
  localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
  localparam logic [7:0] OP_QUAD_PROGRAM_A = 8'h32;
  localparam logic [7:0] OP_QUAD_PROGRAM_B = 8'h38;
  localparam logic [7:0] OP_INFO_ROW_PROG  = 8'h62;
  localparam logic [7:0] OP_SECTOR_ERASE_A = 8'hd7;
  localparam logic [7:0] OP_SECTOR_ERASE_B = 8'h20;
  localparam logic [7:0] OP_ERASE_32K      = 8'h52;
  localparam logic [7:0] OP_ERASE_64K      = 8'hd8;
  localparam logic [7:0] OP_FULL_ERASE_A   = 8'hc7;
  localparam logic [7:0] OP_FULL_ERASE_B   = 8'h60;

  // frame lengths in whole bytes (byte counter saturates at the longest)
  localparam logic [2:0] BYTES_OPCODE  = 3'h1;
  localparam logic [2:0] BYTES_REGDATA = 3'h2;
  localparam logic [2:0] BYTES_ERASE   = 3'h4;
  localparam logic [2:0] BYTES_PROGRAM = 3'h5;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // block index inside the 24-bit address (64 KB blocks)
  localparam int unsigned BLOCK_LSB = 16;
  localparam int unsigned BLOCK_MSB = 18;

  // synchroniser lanes for the pins
  localparam int unsigned PIN_SCK   = 0;
  localparam int unsigned PIN_CS_N  = 1;
  localparam int unsigned PIN_SI    = 2;
  localparam int unsigned PIN_WP_N  = 3;
  localparam int unsigned PIN_PAUSE = 4;
  localparam int unsigned PIN_COUNT = 5;

  typedef enum logic [2:0] {
    DENS_4M,
    DENS_2M,
    DENS_1M,
    DENS_512K,
    DENS_256K
  } fswp_density_type;
endpackage

// ### logic/fswp_protect_map.sv
// maps protect level code and block index to a protected hit
module fswp_protect_map #(
  parameter fswp_pkg::fswp_density_type DENSITY = fswp_pkg::DENS_4M
) (
  // protect level and target
  input  wire logic [3:0] level,
  input  wire logic [2:0] block,
  // result
  output logic            hit
);
  logic [7:0] mask;
  logic [2:0] idx;

  // one bit per 64 KB block; addresses past the array wrap
  always_comb begin
    mask = 8'h00;
    idx  = block;
    unique case (DENSITY)
      fswp_pkg::DENS_4M: begin
        case (level)
          4'h0, 4'hf: mask = 8'h00;
          4'h1:       mask = 8'h80;
          4'h2:       mask = 8'hc0;
          4'h3:       mask = 8'hf0;
          4'hc:       mask = 8'h0f;
          4'hd:       mask = 8'h03;
          4'he:       mask = 8'h01;
          default:    mask = 8'hff;
        endcase
      end
      fswp_pkg::DENS_2M: begin
        idx = {1'b0, block[1:0]};
        case (level)
          4'h0, 4'hf: mask = 8'h00;
          4'h1:       mask = 8'h08;
          4'h2:       mask = 8'h0c;
          4'hd:       mask = 8'h03;
          4'he:       mask = 8'h01;
          default:    mask = 8'h0f;
        endcase
      end
      fswp_pkg::DENS_1M: begin
        idx = {2'h0, block[0]};
        case (level)
          4'h0, 4'hf: mask = 8'h00;
          4'h1:       mask = 8'h02;
          4'he:       mask = 8'h01;
          default:    mask = 8'h03;
        endcase
      end
      fswp_pkg::DENS_512K, fswp_pkg::DENS_256K: begin
        mask = (level == 4'h0 || level == 4'hf) ? 8'h00 : 8'hff;
      end
    endcase
    hit = mask[idx];
  end
endmodule

// ### logic/fswp_status_protect.sv
// status register, write latch and write-protection gate of the serial flash
module fswp_status_protect #(
  parameter fswp_pkg::fswp_density_type DENSITY = fswp_pkg::DENS_4M
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // serial pins
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  // third and fourth pins, read only here
  input  wire logic        data_line_2_in,
  input  wire logic        data_line_3_in,
  // internal operation engine
  output logic             op_start,
  output logic [7:0]       op_code,
  output logic [23:0]      op_addr,
  output logic [7:0]       op_data,
  input  wire logic        op_done,
  // status view
  output logic [7:0]       status_and_protection,
  output logic             quad_pin_enable
);
  // pin synchronisers
  logic [fswp_pkg::PIN_COUNT-1:0] pin_meta;
  logic [fswp_pkg::PIN_COUNT-1:0] pin_sync;
  logic                           sck_prev;
  logic                           cs_prev;

  // serial front end
  logic [7:0]  shreg;
  logic [2:0]  bitpos;
  logic [2:0]  bytes;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [7:0]  wdata;

  // status bits
  logic       busy_flag;
  logic       write_latch;
  logic [3:0] protect_level;
  logic       status_write_lock;

  logic [7:0]  next_shreg;
  logic [2:0]  next_bitpos;
  logic [2:0]  next_bytes;
  logic [7:0]  next_opcode;
  logic [23:0] next_addr;
  logic [7:0]  next_wdata;
  logic        next_busy_flag;
  logic        next_write_latch;
  logic [3:0]  next_protect_level;
  logic        next_quad_pin_enable;
  logic        next_status_write_lock;
  logic        next_so;
  logic        next_so_oe;
  logic        next_op_start;
  logic [7:0]  next_op_code;
  logic [23:0] next_op_addr;
  logic [7:0]  next_op_data;

  // decode helpers
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       paused;
  logic       wp_eff;
  logic       aligned;
  logic       small_dens;
  logic       prot_hit;
  logic       is_unlock;
  logic       is_lock;
  logic       is_swr;
  logic       is_fwr;
  logic       is_prog;
  logic       is_info;
  logic       is_erase;
  logic       is_full;
  logic       swr_ok;
  logic       accept;
  logic [7:0] live_status;

  // two flops per pin; only the second stage and later are looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= 5'h1a;
      pin_sync <= 5'h1a;
      sck_prev <= 1'b0;
      cs_prev  <= 1'b1;
    end else begin
      pin_meta <= {data_line_3_in, data_line_2_in, si, cs_n, sck};
      pin_sync <= pin_meta;
      sck_prev <= pin_sync[fswp_pkg::PIN_SCK];
      cs_prev  <= pin_sync[fswp_pkg::PIN_CS_N];
    end
  end

  // edges of the sampled link clock and select
  assign sck_rise = pin_sync[fswp_pkg::PIN_SCK] & ~sck_prev;
  assign sck_fall = ~pin_sync[fswp_pkg::PIN_SCK] & sck_prev;
  assign cs_rise  = pin_sync[fswp_pkg::PIN_CS_N] & ~cs_prev;

  // pin roles follow quad enable; in quad mode neither pin gates anything
  assign paused = ~quad_pin_enable & ~pin_sync[fswp_pkg::PIN_PAUSE];
  assign wp_eff = quad_pin_enable | pin_sync[fswp_pkg::PIN_WP_N];

  assign live_status = {status_write_lock, quad_pin_enable, protect_level,
                        write_latch, busy_flag};

  assign small_dens = (DENSITY == fswp_pkg::DENS_512K) || (DENSITY == fswp_pkg::DENS_256K);

  fswp_protect_map #(
    .DENSITY (DENSITY)
  ) u_map (
    .level (protect_level),
    .block (addr[fswp_pkg::BLOCK_MSB:fswp_pkg::BLOCK_LSB]),
    .hit   (prot_hit)
  );

  // command classes; a frame must end on a byte boundary with the right length
  always_comb begin
    aligned   = (bitpos == 3'h0);
    is_unlock = (opcode == fswp_pkg::OP_WRITE_UNLOCK) && (bytes == fswp_pkg::BYTES_OPCODE);
    is_lock   = (opcode == fswp_pkg::OP_WRITE_LOCK) && (bytes == fswp_pkg::BYTES_OPCODE);
    is_swr    = (opcode == fswp_pkg::OP_STATUS_WRITE) && (bytes == fswp_pkg::BYTES_REGDATA);
    is_fwr    = (opcode == fswp_pkg::OP_FUNCTION_WRITE) && (bytes == fswp_pkg::BYTES_REGDATA);
    is_info   = (opcode == fswp_pkg::OP_INFO_ROW_PROG) && (bytes == fswp_pkg::BYTES_PROGRAM);
    is_prog   = ((opcode == fswp_pkg::OP_PAGE_PROGRAM) || (opcode == fswp_pkg::OP_QUAD_PROGRAM_A)
                || (opcode == fswp_pkg::OP_QUAD_PROGRAM_B)) && (bytes == fswp_pkg::BYTES_PROGRAM);
    is_erase  = ((opcode == fswp_pkg::OP_SECTOR_ERASE_A) || (opcode == fswp_pkg::OP_SECTOR_ERASE_B)
                || (opcode == fswp_pkg::OP_ERASE_32K) || (opcode == fswp_pkg::OP_ERASE_64K))
                && (bytes == fswp_pkg::BYTES_ERASE);
    is_full   = ((opcode == fswp_pkg::OP_FULL_ERASE_A) || (opcode == fswp_pkg::OP_FULL_ERASE_B))
                && (bytes == fswp_pkg::BYTES_OPCODE)
                && (DENSITY != fswp_pkg::DENS_256K)
                && (protect_level == 4'h0);
    swr_ok    = ~(status_write_lock & ~wp_eff);
    // every write-type path needs the latch and an idle engine
    accept    = cs_rise && aligned && !busy_flag && write_latch
                && ((is_swr && swr_ok) || is_fwr || is_info || is_full
                || ((is_prog || is_erase) && !prot_hit));
  end

  // serial front end, status bits and launch of internal operations
  always_comb begin
    next_shreg             = shreg;
    next_bitpos            = bitpos;
    next_bytes             = bytes;
    next_opcode            = opcode;
    next_addr              = addr;
    next_wdata             = wdata;
    next_busy_flag         = busy_flag;
    next_write_latch       = write_latch;
    next_protect_level     = protect_level;
    next_quad_pin_enable   = quad_pin_enable;
    next_status_write_lock = status_write_lock;
    next_so                = so;
    next_so_oe             = so_oe;
    next_op_start          = 1'b0;
    next_op_code           = op_code;
    next_op_addr           = op_addr;
    next_op_data           = op_data;

    if (pin_sync[fswp_pkg::PIN_CS_N]) begin
      // deselected: frame counters restart, output released
      next_bitpos = 3'h0;
      next_bytes  = 3'h0;
      next_so_oe  = 1'b0;
    end else if (!paused) begin
      if (sck_rise) begin
        next_shreg  = {shreg[6:0], pin_sync[fswp_pkg::PIN_SI]};
        next_bitpos = bitpos + 3'h1;
        if (bitpos == fswp_pkg::BIT_LAST) begin
          if (bytes != fswp_pkg::BYTES_PROGRAM) begin
            next_bytes = bytes + 3'h1;
          end
          unique case (bytes)
            3'h0: next_opcode = next_shreg;
            3'h1: begin
              next_addr[23:16] = next_shreg;
              next_wdata       = next_shreg;
            end
            3'h2: next_addr[15:8] = next_shreg;
            3'h3: next_addr[7:0]  = next_shreg;
            default: ;
          endcase
        end
      end
      // status bits leave msb first, one per falling edge, repeating
      if (sck_fall && (bytes != 3'h0) && (opcode == fswp_pkg::OP_STATUS_READ)) begin
        next_so    = live_status[3'h7 - bitpos];
        next_so_oe = 1'b1;
      end
    end else begin
      // pause tri-states the output but keeps the frame position
      next_so_oe = 1'b0;
    end

    // latch commands are plain register writes; refused while busy
    if (cs_rise && aligned && !busy_flag) begin
      if (is_unlock) begin
        next_write_latch = 1'b1;
      end else if (is_lock) begin
        next_write_latch = 1'b0;
      end
    end

    if (accept) begin
      next_busy_flag = 1'b1;
      next_op_start  = 1'b1;
      next_op_addr   = addr;
      next_op_data   = wdata;
      next_op_code   = (small_dens && opcode == fswp_pkg::OP_ERASE_64K)
                       ? fswp_pkg::OP_ERASE_32K : opcode;
      if (is_swr) begin
        // latch bit of the data byte is dropped on purpose
        next_status_write_lock = wdata[fswp_pkg::LOCK_BIT];
        next_quad_pin_enable   = wdata[fswp_pkg::QUAD_BIT];
        next_protect_level     = wdata[fswp_pkg::PROTECT_MSB:fswp_pkg::PROTECT_LSB];
      end
    end

    // engine finished: busy and latch drop together
    if (busy_flag && op_done) begin
      next_busy_flag   = 1'b0;
      next_write_latch = 1'b0;
    end
  end

  // register stage; non-volatile bits restart from their shipped zero
  always_ff @(posedge clk) begin
    if (rst) begin
      shreg             <= 8'h00;
      bitpos            <= 3'h0;
      bytes             <= 3'h0;
      opcode            <= 8'h00;
      addr              <= 24'h000000;
      wdata             <= 8'h00;
      busy_flag         <= fswp_pkg::STATUS_RESET[fswp_pkg::BUSY_BIT];
      write_latch       <= fswp_pkg::STATUS_RESET[fswp_pkg::LATCH_BIT];
      protect_level     <= fswp_pkg::STATUS_RESET[fswp_pkg::PROTECT_MSB:fswp_pkg::PROTECT_LSB];
      quad_pin_enable   <= fswp_pkg::STATUS_RESET[fswp_pkg::QUAD_BIT];
      status_write_lock <= fswp_pkg::STATUS_RESET[fswp_pkg::LOCK_BIT];
      so                <= 1'b0;
      so_oe             <= 1'b0;
      op_start          <= 1'b0;
      op_code           <= 8'h00;
      op_addr           <= 24'h000000;
      op_data           <= 8'h00;
    end else begin
      shreg             <= next_shreg;
      bitpos            <= next_bitpos;
      bytes             <= next_bytes;
      opcode            <= next_opcode;
      addr              <= next_addr;
      wdata             <= next_wdata;
      busy_flag         <= next_busy_flag;
      write_latch       <= next_write_latch;
      protect_level     <= next_protect_level;
      quad_pin_enable   <= next_quad_pin_enable;
      status_write_lock <= next_status_write_lock;
      so                <= next_so;
      so_oe             <= next_so_oe;
      op_start          <= next_op_start;
      op_code           <= next_op_code;
      op_addr           <= next_op_addr;
      op_data           <= next_op_data;
    end
  end

  assign status_and_protection = live_status;

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence launch_seq;
    cs_rise && accept;
  endsequence

  sequence finish_seq;
    busy_flag && op_done;
  endsequence

  busy_launch_a: assert property (launch_seq |=> busy_flag && op_start)
    else $error("accepted command did not raise busy");

  busy_finish_a: assert property (finish_seq |=> !busy_flag && !write_latch)
    else $error("finished operation left busy or latch set");

  unlock_sets_a: assert property (cs_rise && is_unlock && aligned && !busy_flag |=> write_latch)
    else $error("write-unlock did not set the latch");

  lock_clears_a: assert property (cs_rise && is_lock && aligned && !busy_flag |=> !write_latch)
    else $error("write-lock did not clear the latch");

  latch_gate_a: assert property (op_start |-> $past(write_latch) && !$past(busy_flag))
    else $error("operation launched without latch");

  ignored_idle_a: assert property (cs_rise && !accept && !busy_flag |=> !busy_flag && !op_start)
    else $error("ignored command changed busy");

  full_erase_prot_a: assert property (cs_rise && protect_level != 4'h0 |=>
    !(op_start && (op_code == fswp_pkg::OP_FULL_ERASE_A || op_code == fswp_pkg::OP_FULL_ERASE_B)))
    else $error("full erase ran with protect bits set");

  region_inhibit_a: assert property (cs_rise && (is_prog || is_erase) && prot_hit |=> !op_start)
    else $error("program or erase into protected region");

  lock_pin_a: assert property (cs_rise && is_swr && status_write_lock && !wp_eff |=>
    $stable(live_status[7:2]) && !busy_flag)
    else $error("locked status write changed bits");

  swr_latch_a: assert property (launch_seq ##0 is_swr |=> write_latch)
    else $error("status write altered the latch");

  nv_only_swr_a: assert property (!(cs_rise && accept && is_swr) |=> $stable(live_status[7:2]))
    else $error("protect bits changed outside status write");

  // bit picked from the previous cycle's status and position, so a busy change mid-frame is tolerated
  read_bit_a: assert property (sck_fall && !pin_sync[fswp_pkg::PIN_CS_N] && !paused && bytes != 3'h0
    && opcode == fswp_pkg::OP_STATUS_READ
    |=> so_oe && (so == ((($past(live_status) >> (3'h7 - $past(bitpos))) & 8'h01) != 8'h00)))
    else $error("status bit on output wrong");
endmodule

// ### testbench/fswp_host_model.sv
// serial host model that frames commands for the status and protection block
module fswp_host_model #(
  parameter int HALF_NS = 24
) (
  // serial pins driven by the host
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  // answer from the device
  input  wire logic so,
  input  wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mode3 = 1'b0;  // sck idle level between frames

  // the link clock only runs inside a frame
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // shift n bytes out msb first; so is sampled late in the high phase, well after the falling-edge update
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    sck <= mode3;
    #(HALF_NS);
    cs_n <= 1'b0;
    for (int i = 39; i >= 40 - 8 * n; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      #(HALF_NS);
      sck <= 1'b1;
      #(HALF_NS);
      rx[i] = so_oe ? so : 1'bx;
    end
    if (!mode3) begin
      sck <= 1'b0;
    end
    #(HALF_NS);
    cs_n <= 1'b1;
    si <= ~si;  // released line must not look like held data
    #(HALF_NS * 4);
  endtask
endmodule

// ### testbench/fswp_status_protect_tb_top.sv
// bench top: host model, operation engine stand-in and result checking
module fswp_status_protect_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp_n = 1'b1;
  // pause pin driven rather than tied high, since the pause test pulls it low once quad is off again
  logic        pause_n = 1'b1;
  logic [39:0] rx_pause;
  logic        op_done = 1'b0;
  logic        sck, cs_n, si, so, so_oe, op_start, quad_pin_enable;
  logic [7:0]  op_code, op_data, st, exp_st, lf;
  logic [23:0] op_addr;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          done_cnt = 0;
  logic [7:0]  ops[12] = '{8'h01, 8'h42, 8'h02, 8'h32, 8'h38, 8'h62, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  int          lens[12] = '{2, 2, 5, 5, 5, 5, 4, 4, 4, 4, 1, 1};

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  fswp_status_protect #(.DENSITY(fswp_pkg::DENS_4M)) u_dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .data_line_2_in(wp_n), .data_line_3_in(pause_n), .op_start(op_start), .op_code(op_code),
    .op_addr(op_addr), .op_data(op_data), .op_done(op_done), .status_and_protection(st),
    .quad_pin_enable(quad_pin_enable));
  fswp_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // pseudo-random source: 8-bit maximal-length shift register, seeded with 60
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // expected map of the 4 Mbit part: protect code and 64 KB block to protected
  function automatic logic prot4m(input logic [3:0] c, input logic [2:0] b);
    case (c)
      4'h0, 4'hf: return 1'b0;
      4'h1: return b == 3'h7;
      4'h2: return b >= 3'h6;
      4'h3: return b >= 3'h4;
      4'hc: return b <= 3'h3;
      4'hd: return b <= 3'h1;
      4'he: return b == 3'h0;
      default: return 1'b1;
    endcase
  endfunction

  // one frame, then status polling until idle; ok says whether the device should act on it
  task automatic frame(input logic [39:0] tx, input int n, input logic ok);
    logic [39:0] rx;
    if (ok) begin
      case (tx[39:32])
        8'h06: exp_st[1] = 1'b1;
        8'h04: exp_st[1] = 1'b0;
        8'h01: exp_st = {tx[31:26], 2'b00};
        default: exp_st[1] = 1'b0;
      endcase
      if (tx[39:32] != 8'h06 && tx[39:32] != 8'h04) exp_q.push_back({tx[39:8], n > 3});
    end
    u_host.xfer(tx, n, rx);
    for (int i = 0; i < 20; i++) begin
      u_host.xfer(40'h05_0000_0000, 2, rx);
      if (rx[24] === 1'b0) break;
    end
    check(rx[31:24], exp_st);
    check(st, exp_st);
  endtask

  task automatic wen();
    frame(40'h06_0000_0000, 1, 1'b1);
  endtask

  task automatic wstat(input logic [7:0] d, input logic ok);
    wen();
    frame({8'h01, d, 24'h0}, 2, ok);
  endtask

  // engine stand-in: each launch is matched to the oldest note and finished four cycles later
  always @(posedge clk) begin
    op_done <= (done_cnt == 1);
    if (op_start === 1'b1) begin
      done_cnt <= 4;
      check(st[0], 1'b1);
      if (exp_q.size() == 0) check({24'h0, op_code}, 32'h100);
      else begin
        e = exp_q.pop_front();
        check(op_code, e[32:25]);
        if (e[0]) check(op_addr, e[24:1]);
        else if (e[32:25] == 8'h01 || e[32:25] == 8'h42) check({24'h0, op_data}, {24'h0, e[24:17]});
      end
    end else if (done_cnt > 0) begin
      done_cnt <= done_cnt - 1;
    end
  end

  // hang guard: a clean run takes about 52000 cycles, so this leaves half again as margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    exp_st = 8'h00;
    lf = 8'h3c;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(st, 8'h00);
    for (int i = 0; i < 12; i++) frame({ops[i], 32'h0001_2300}, lens[i], 1'b0);
    $display("test no_latch done");
    u_host.mode3 = 1'b1;
    wen();
    u_host.mode3 = 1'b0;
    frame(40'h04_0000_0000, 1, 1'b1);
    $display("test latch done");
    for (int i = 0; i < 12; i++) begin
      wen();
      frame({ops[i], 32'h0001_2300}, lens[i], 1'b1);
    end
    $display("test accepted done");
    // every protect code against a pseudo-random block, then a full erase
    for (int c = 0; c < 16; c++) begin
      wstat({2'b00, c[3:0], 2'b11}, 1'b1);
      lf = lfsr_next(lf);
      wen();
      frame({8'hd7, 5'h0, lf[2:0], lf, 16'h0}, 4, !prot4m(c[3:0], lf[2:0]));
      wen();
      frame(40'hc7_0000_0000, 1, c == 0);
    end
    $display("test protect done");
    wstat(8'h80, 1'b1);
    @(posedge clk) wp_n <= 1'b0;
    wstat(8'h3c, 1'b0);
    frame(40'h04_0000_0000, 1, 1'b1);
    @(posedge clk) wp_n <= 1'b1;
    wstat(8'hc0, 1'b1);
    check(quad_pin_enable, 1'b1);
    @(posedge clk) wp_n <= 1'b0;
    wstat(8'h00, 1'b1);
    check(exp_q.size(), 0);
    $display("test lock done");
    // quad is off again: a low pause pin freezes the frame, so the unlock is lost
    @(posedge clk) pause_n <= 1'b0;
    u_host.xfer(40'h06_0000_0000, 1, rx_pause);
    @(posedge clk) pause_n <= 1'b1;
    frame(40'h05_0000_0000, 2, 1'b0);
    $display("test pause done");
    stop_test();
  end
endmodule
